// [verilog/ext_bus_map.svh]
/*
  constants for the external bus address phase block.
  assumes inclusion by the package and the design modules.
*/
`ifndef EXT_BUS_MAP_SVH
`define EXT_BUS_MAP_SVH
`define EB_ADDR_W 34
`define BURST_LENGTH_CODE_FOUR 2'h1
`define BURST_LENGTH_CODE_NONE 2'h0
`define EB_BEATS 3'h4
`define EB_BEAT_LAST 2'h3
`define EB_SUB_BITS 2
`define EB_SYNC_SETTLE 2'h2
`endif

// [verilog/ext_bus_pkg.sv]
/*
  types for the external bus address phase block.
  assumes the map header sits beside it.
*/
`include "ext_bus_map.svh"
package ext_bus_pkg;
  typedef struct packed {
    logic [`EB_ADDR_W-1:0] addr;
    logic fetch;
    logic write;
    logic burst;
  } bus_req_t;
  typedef struct packed {
    logic [`EB_ADDR_W-1:0] addr;
    logic fetch_flag;
    logic write_flag;
    logic burst_flag;
    logic burst_first_beat;
    logic burst_final_beat;
    logic [1:0] burst_length_code;
  } addr_phase_t;
endpackage

// [verilog/burst_addr_gen.sv]
/*
  beat address generator: sequential or sub-block order within a line.
  assumes a line of four words and a stable base address.
*/
`timescale 1ns/1ps
`include "ext_bus_map.svh"
module burst_addr_gen #(
  parameter int ADDR_W = `EB_ADDR_W
) (
  input wire logic [ADDR_W-1:0] i_base,
  input wire logic [1:0] i_beat,
  input wire logic i_subblock,
  output logic [ADDR_W-1:0] o_addr
);
  if (ADDR_W < `EB_SUB_BITS + 1) begin : g_width_check
    $error("address too narrow");
  end
  logic [`EB_SUB_BITS-1:0] word;
  always_comb begin
    if (i_subblock) begin
      word = i_base[`EB_SUB_BITS-1:0] ^ i_beat;
    end else begin
      word = i_base[`EB_SUB_BITS-1:0] + i_beat;
    end
    o_addr = {i_base[ADDR_W-1:`EB_SUB_BITS], word};
  end
endmodule

// [verilog/ext_bus_addr_phase.sv]
/*
  address phase and qualifier driver of the core's external bus.
  assumes requests from core logic on i_clock; bus inputs from the target.
*/
`timescale 1ns/1ps
`include "ext_bus_map.svh"
module ext_bus_addr_phase
  import ext_bus_pkg::*;
#(
  parameter int ADDR_W = `EB_ADDR_W
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_req_valid,
  input wire bus_req_t i_req,
  output logic o_req_ready,
  input wire logic i_addr_accept_ready,
  input wire logic i_subblock_order_sel,
  input wire logic i_write_data_accept,
  input wire logic i_read_data_valid,
  output logic o_addr_phase_valid,
  output addr_phase_t o_phase,
  output logic o_beat_accepted,
  output logic o_write_data_taken,
  output logic o_read_data_seen
);
  // the package types fix the address width
  if (ADDR_W != `EB_ADDR_W) begin : g_width_check
    $error("address width must match bus");
  end
  if ((1 << `EB_SUB_BITS) != `EB_BEATS) begin : g_beats_check
    $error("beat count must fill one line");
  end

  // one-hot transaction states
  typedef enum logic [2:0] {
    IDLE = 3'b001,
    ADDR = 3'b010,
    DATA = 3'b100
  } state_t;

  // two-flop synchronisers for bus inputs
  logic [3:0] sync1_reg, sync2_reg;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= {i_read_data_valid, i_write_data_accept, i_subblock_order_sel, i_addr_accept_ready};
      sync2_reg <= sync1_reg;
    end
  end
  logic ardy, sblock, wdrdy, rdval;
  assign ardy = sync2_reg[0];
  assign sblock = sync2_reg[1];
  assign wdrdy = sync2_reg[2];
  assign rdval = sync2_reg[3];

  state_t state_reg, state_next;
  bus_req_t req_reg, req_next;
  logic [1:0] beat_reg, beat_next;
  logic order_reg, order_next;
  logic valid_reg, valid_next;
  logic wr_pend_reg, wr_pend_next;
  addr_phase_t phase_reg, phase_next;
  logic [ADDR_W-1:0] beat_addr;
  // edges spent in the current state, saturating
  logic [1:0] age_reg, age_next;
  logic fresh;
  logic data_done;

  burst_addr_gen #(.ADDR_W(ADDR_W)) u_gen (
    .i_base(req_reg.addr),
    .i_beat(beat_next),
    .i_subblock(order_next),
    .o_addr(beat_addr)
  );

  function automatic logic is_last(input logic burst, input logic [1:0] beat);
    is_last = !burst || (beat == `EB_BEAT_LAST);
  endfunction

  // bus inputs lag two edges behind the pins; a strobe counts only once
  // the state has lasted that long, so a level left from the last phase is not taken
  always_comb begin
    age_next = age_reg;
    if (state_next != state_reg) begin
      age_next = 2'h0;
    end else if (age_reg != `EB_SYNC_SETTLE) begin
      age_next = age_reg + 2'h1;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      age_reg <= 2'h0;
    end else begin
      age_reg <= age_next;
    end
  end

  assign fresh = (age_reg == `EB_SYNC_SETTLE);

  logic accept;
  assign accept = valid_reg && fresh && ardy;
  // a beat's data phase ends on write-data ready or on read data
  assign data_done = (state_reg == DATA) && fresh && (wr_pend_reg ? wdrdy : rdval);
  assign o_req_ready = (state_reg == IDLE);

  always_comb begin
    state_next = state_reg;
    req_next = req_reg;
    beat_next = beat_reg;
    order_next = order_reg;
    valid_next = valid_reg;
    wr_pend_next = wr_pend_reg;
    phase_next = phase_reg;
    unique case (state_reg)
      IDLE: begin
        if (i_req_valid) begin
          req_next = i_req;
          beat_next = 2'h0;
          // ordering is fixed for the whole transaction
          order_next = sblock;
          valid_next = 1'b1;
          state_next = ADDR;
        end
      end
      ADDR: begin
        if (accept) begin
          valid_next = 1'b0;
          wr_pend_next = req_reg.write;
          state_next = DATA;
        end
      end
      DATA: begin
        if (data_done) begin
          wr_pend_next = 1'b0;
          if (is_last(req_reg.burst, beat_reg)) begin
            state_next = IDLE;
          end else begin
            beat_next = beat_reg + 2'h1;
            valid_next = 1'b1;
            state_next = ADDR;
          end
        end
      end
      default: state_next = IDLE;
    endcase
    // qualifiers are captured once, as valid rises, and then held
    if (valid_next && !valid_reg) begin
      phase_next.addr = (state_reg == IDLE) ? i_req.addr : beat_addr;
      phase_next.fetch_flag = req_next.fetch;
      phase_next.write_flag = req_next.write;
      phase_next.burst_flag = req_next.burst;
      phase_next.burst_first_beat = req_next.burst && (beat_next == 2'h0);
      phase_next.burst_final_beat = req_next.burst && (beat_next == `EB_BEAT_LAST);
      phase_next.burst_length_code = req_next.burst ? `BURST_LENGTH_CODE_FOUR : `BURST_LENGTH_CODE_NONE;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= IDLE;
      req_reg <= '0;
      beat_reg <= 2'h0;
      order_reg <= 1'b0;
      valid_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      phase_reg <= '0;
    end else begin
      state_reg <= state_next;
      req_reg <= req_next;
      beat_reg <= beat_next;
      order_reg <= order_next;
      valid_reg <= valid_next;
      wr_pend_reg <= wr_pend_next;
      phase_reg <= phase_next;
    end
  end

  // one pulse per beat for the core's side
  logic acc_reg, wtaken_reg, rseen_reg;
  logic acc_next, wtaken_next, rseen_next;
  always_comb begin
    acc_next = accept;
    wtaken_next = data_done && wr_pend_reg;
    rseen_next = data_done && !wr_pend_reg;
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      acc_reg <= 1'b0;
      wtaken_reg <= 1'b0;
      rseen_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      wtaken_reg <= wtaken_next;
      rseen_reg <= rseen_next;
    end
  end

  assign o_addr_phase_valid = valid_reg;
  assign o_phase = phase_reg;
  assign o_beat_accepted = acc_reg;
  assign o_write_data_taken = wtaken_reg;
  assign o_read_data_seen = rseen_reg;
endmodule

// [bench/ext_bus_addr_phase_props.sv]
/* address phase checker.
   assumes a bind into the block. */
`timescale 1ns/1ps
module ext_bus_addr_phase_props
  import ext_bus_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_req_valid,
  input wire logic o_req_ready,
  input wire logic i_addr_accept_ready,
  input wire logic o_addr_phase_valid,
  input wire addr_phase_t o_phase,
  input wire logic o_write_data_taken,
  input wire logic o_beat_accepted,
  input wire logic o_read_data_seen
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  wire logic v = o_addr_phase_valid;
  wire addr_phase_t p = o_phase;
  a_rise_req: assert property ($rose(v) && !p.burst_flag |-> $past(i_req_valid && o_req_ready))
    else $error("stray valid");
  a_idle_low: assert property (o_req_ready |-> !v) else $error("valid in idle");
  a_len_four: assert property (v && p.burst_flag |-> p.burst_length_code == 2'h1) else $error("length");
  a_single_quiet: assert property (v && !p.burst_flag |->
    !(p.burst_first_beat || p.burst_final_beat || p.burst_length_code)) else $error("single");
  a_first_beat: assert property (v && p.burst_first_beat |-> p.burst_flag && !p.burst_final_beat)
    else $error("first");
  a_hold_phase: assert property (v && $past(v) |-> $stable(p)) else $error("hold");
  a_accept_gate: assert property ($fell(v) |-> $past(i_addr_accept_ready, 3)) else $error("accept");
  a_accept_pulse: assert property ($fell(v) |-> o_beat_accepted) else $error("accept pulse");
  a_read_after: assert property (o_read_data_seen |-> !p.write_flag && !$past(v))
    else $error("rdata");
  a_wdata_after: assert property (o_write_data_taken |-> p.write_flag && !$past(v))
    else $error("wdata");
  c_burst_end: cover property (v && p.burst_final_beat);
  c_wr_taken: cover property (o_write_data_taken);
  c_single: cover property (v && !p.burst_flag);
  c_rd_seen: cover property (o_read_data_seen);
endmodule
bind ext_bus_addr_phase ext_bus_addr_phase_props i_props (.*);

// [bench/ext_bus_target.sv]
/* target model: address ready after i_wait cycles, then data.
   assumes i_done marks data as seen. */
`timescale 1ns/1ps
module ext_bus_target (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire logic i_write,
  input wire logic i_done,
  input wire logic [2:0] i_wait,
  output logic o_ready,
  output logic o_rdval,
  output logic o_wdrdy
);
  logic [2:0] cnt;
  logic data;
  assign {o_wdrdy, o_rdval} = {data & i_write, data & ~i_write};
  always @(negedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      {cnt, o_ready, data} <= '0;
    end else begin
      cnt <= i_valid ? cnt + 3'h1 : 3'h0;
      o_ready <= i_valid && (o_ready || cnt >= i_wait);
      if (o_ready && !i_valid) data <= 1'b1;
      else if (i_done) data <= 1'b0;
    end
  end
endmodule

// [bench/core_ext_bus_addr_phase_test.sv]
/* random requests into the block against a target model.
   assumes checker and model compiled first. */
`timescale 1ns/1ps
module core_ext_bus_addr_phase_test;
  import ext_bus_pkg::*;
  logic i_clock = 1'b0, i_rst = 1'b1, rv = 1'b0, sub = 1'b0;
  logic [2:0] slow = 3'h0;
  logic rr, ar, wr, rd, av, wt, rs, ba;
  bus_req_t rq = '0;
  addr_phase_t ph;
  int fail_count = 0, total_checks = 0;
  int acc_cnt = 0, wt_cnt = 0, rs_cnt = 0, a0 = 0, w0 = 0, r0 = 0, nb = 0;
  logic [31:0] sd = 32'hef63;
  ext_bus_addr_phase i_ext_bus_addr_phase (.i_clock, .i_rst, .i_req_valid(rv), .i_req(rq), .o_req_ready(rr),
    .i_addr_accept_ready(ar), .i_subblock_order_sel(sub), .i_write_data_accept(wr), .i_read_data_valid(rd),
    .o_addr_phase_valid(av), .o_phase(ph), .o_beat_accepted(ba), .o_write_data_taken(wt), .o_read_data_seen(rs));
  ext_bus_target i_ext_bus_target (.i_clock, .i_rst, .i_valid(av), .i_write(ph.write_flag), .i_done(wt | rs),
    .i_wait(slow), .o_ready(ar), .o_rdval(rd), .o_wdrdy(wr));
  initial forever #12.5 i_clock = ~i_clock;
  always @(negedge i_clock) begin
    acc_cnt += ba;
    wt_cnt += wt;
    rs_cnt += rs;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  function automatic addr_phase_t ex(input bus_req_t r, input logic [1:0] b);
    logic [1:0] lo;
    lo = sub ? r.addr[1:0] ^ b : r.addr[1:0] + b;
    return '{{r.addr[33:2], lo}, r.fetch, r.write, r.burst, r.burst && !b, r.burst && &b, {1'b0, r.burst}};
  endfunction
  task automatic check(input string nm, input logic [63:0] seen, want);
    total_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic close_out();
    if (fail_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wait_on(ref logic s, input logic lvl);
    for (int k = 0; s !== lvl; k++) begin
      if (k > 40) begin
        check("wait", s, lvl);
        close_out();
      end
      @(negedge i_clock);
    end
  endtask
  initial begin
    repeat (3) @(posedge i_clock);
    @(negedge i_clock);
    i_rst = 1'b0;
    for (int t = 0; t < 40; t++) begin
      sd = xs(sd);
      sub = t < 2 ? t[0] : sd[1];
      slow = sd[4:2];
      rq = '{{sd, sd[6:5] | {2{t == 1}}}, sd[7] & ~sd[8], sd[8], t < 2 || sd[9]};
      repeat (3) @(negedge i_clock);
      rv = 1'b1;
      @(negedge i_clock);
      rv = 1'b0;
      nb = rq.burst ? 4 : 1;
      for (int b = 0; b < nb; b++) begin
        wait_on(av, 1'b1);
        check("phase", ph, ex(rq, b[1:0]));
        wait_on(av, 1'b0);
      end
      wait_on(rr, 1'b1);
      @(posedge i_clock);
      check("accepted", acc_cnt - a0, nb);
      check("wtaken", wt_cnt - w0, rq.write ? nb : 0);
      check("rseen", rs_cnt - r0, rq.write ? 0 : nb);
      a0 = acc_cnt;
      w0 = wt_cnt;
      r0 = rs_cnt;
      @(negedge i_clock);
    end
    close_out();
  end
endmodule
